//--- logic/hwmon_fan_temp_config_bank.sv
// Fan and temperature configuration bank, an APB slave with one wait state per access.
// Assumes APB signals, over-limit levels and tach pins are synchronous to pclk.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "hwmon_consts.svh"
`default_nettype none
module hwmon_fan_temp_config_bank #(
  // Identifier value is arbitrary
  parameter logic [15:0] MAKER_ID = 16'h1D2E
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic aux_temp_over,
  input wire logic cpu_temp_over,
  input wire logic aux_tach_first_div_msb,
  input wire logic [1:0] cpu_tach_second_div_low,
  input wire hwmon_pkg::tach_t tach_in,
  output hwmon_pkg::tach_t tach_drive,
  output hwmon_pkg::tach_t tach_oe_n,
  output hwmon_pkg::tach_t tach_sample,
  output logic overtemp_out_n,
  output hwmon_pkg::fan_cfg_t fan_cfg
);

  // ==========================================================
  // Decoding helpers
  // ==========================================================
  function automatic hwmon_pkg::temp_src_t src_first(input logic [2:0] code,
                                                     input hwmon_pkg::temp_src_t base);
    unique case (code)
      3'h0: src_first = base;
      3'h2: src_first = hwmon_pkg::SRC_PECI1;
      3'h3: src_first = hwmon_pkg::SRC_PECI2;
      3'h4: src_first = hwmon_pkg::SRC_PECI3;
      3'h5: src_first = hwmon_pkg::SRC_PECI4;
      default: src_first = hwmon_pkg::SRC_NONE;
    endcase
  endfunction : src_first

  function automatic hwmon_pkg::temp_src_t src_second(input logic [2:0] code);
    unique case (code)
      3'h0: src_second = hwmon_pkg::SRC_SYS;
      3'h1: src_second = hwmon_pkg::SRC_CPU;
      3'h2: src_second = hwmon_pkg::SRC_AUX;
      3'h3: src_second = hwmon_pkg::SRC_NONE;
      3'h4: src_second = hwmon_pkg::SRC_PECI1;
      3'h5: src_second = hwmon_pkg::SRC_PECI2;
      3'h6: src_second = hwmon_pkg::SRC_PECI3;
      3'h7: src_second = hwmon_pkg::SRC_PECI4;
    endcase
  endfunction : src_second

  function automatic logic [7:0] fan_div(input logic [2:0] code);
    fan_div = 8'h01 << code;
  endfunction : fan_div

  function automatic logic [6:0] adc_div(input logic [1:0] code);
    adc_div = 7'h01 << {code, 1'b0};
  endfunction : adc_div

  // ==========================================================
  // State
  // ==========================================================
  hwmon_pkg::state_t state_ff;
  hwmon_pkg::state_t nxt_state;

  logic [9:0] idx;
  logic aligned;
  logic hit;
  logic access;
  logic ovt_active;

  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign hit = aligned && (idx >= `IDX_SRC_A) && (idx <= `IDX_MAKER);
  assign access = psel && penable;
  assign ovt_active = (aux_temp_over && !state_ff.int_ovt[`OVT_AUX_DIS]) ||
                      (cpu_temp_over && !state_ff.int_ovt[`OVT_CPU_DIS]);

  always_comb begin
    nxt_state = state_ff;
    if (ce) begin
      // Fixed single wait state keeps every APB output straight off a flop
      nxt_state.pready = access && !state_ff.pready;
      if (access && !state_ff.pready) begin
        nxt_state.pslverr = !hit;
        nxt_state.prdata = 32'h0000_0000;
        if (hit && !pwrite) begin
          unique case (idx)
            `IDX_SRC_A: nxt_state.prdata[7:0] = state_ff.src_a;
            `IDX_SRC_B: nxt_state.prdata[7:0] = state_ff.src_b;
            `IDX_DIV_ADC: nxt_state.prdata[7:0] = state_ff.div_adc;
            `IDX_INT_OVT: nxt_state.prdata[7:0] = state_ff.int_ovt;
            `IDX_PIN_DIR: nxt_state.prdata[7:0] = state_ff.pin_dir;
            `IDX_BANK: nxt_state.prdata[7:0] = state_ff.bank_sel;
            default: nxt_state.prdata[7:0] = state_ff.bank_sel[`BANK_HI_BYTE] ?
                                             MAKER_ID[15:8] : MAKER_ID[7:0];
          endcase
        end
      end
      // Writes land on the completing edge only; reserved bits are stored as written
      if (access && state_ff.pready && pwrite && hit && pstrb[0]) begin
        unique case (idx)
          `IDX_SRC_A: nxt_state.src_a = pwdata[7:0];
          `IDX_SRC_B: nxt_state.src_b = pwdata[7:0];
          `IDX_DIV_ADC: nxt_state.div_adc = pwdata[7:0];
          `IDX_INT_OVT: nxt_state.int_ovt = pwdata[7:0];
          `IDX_PIN_DIR: nxt_state.pin_dir = pwdata[7:0];
          `IDX_BANK: nxt_state.bank_sel = pwdata[7:0];
          default: nxt_state.bank_sel = state_ff.bank_sel;
        endcase
      end
      nxt_state.overtemp_n = state_ff.int_ovt[`OVT_POL] ? ovt_active : !ovt_active;
      nxt_state.oe_n.aux = nxt_state.pin_dir[`PIN_AUX_IN];
      nxt_state.drive.aux = nxt_state.pin_dir[`PIN_AUX_VAL];
      nxt_state.oe_n.cpu = nxt_state.pin_dir[`PIN_CPU_IN];
      nxt_state.drive.cpu = nxt_state.pin_dir[`PIN_CPU_VAL];
      nxt_state.oe_n.sys = nxt_state.pin_dir[`PIN_SYS_IN];
      nxt_state.drive.sys = nxt_state.pin_dir[`PIN_SYS_VAL];
      nxt_state.sample = tach_in;
      nxt_state.cfg.aux_drive_src = src_first(nxt_state.src_a[`SRC_A_AUX_HI:`SRC_A_AUX_LO],
                                              hwmon_pkg::SRC_AUX);
      nxt_state.cfg.cpu_first_src = src_first(nxt_state.src_a[`SRC_A_CPU_HI:`SRC_A_CPU_LO],
                                              hwmon_pkg::SRC_CPU);
      nxt_state.cfg.cpu_second_src = src_second(nxt_state.src_b[`SRC_B_HI:`SRC_B_LO]);
      nxt_state.cfg.aux_tach_first_div = fan_div({aux_tach_first_div_msb,
                                                  nxt_state.div_adc[`DIV_AUX_HI:`DIV_AUX_LO]});
      nxt_state.cfg.cpu_tach_second_div = fan_div({nxt_state.int_ovt[`INT_CPU2_DIV_MSB],
                                                   cpu_tach_second_div_low});
      nxt_state.cfg.adc_clk_div = adc_div(nxt_state.div_adc[`ADC_HI:`ADC_LO]);
      nxt_state.cfg.cmp_int_mode = nxt_state.int_ovt[`INT_CMP_MODE];
      nxt_state.cfg.sys_once_int_mode = nxt_state.int_ovt[`INT_SYS_ONCE];
      nxt_state.cfg.beep_aux_second = nxt_state.bank_sel[`BEEP_AUX2];
      nxt_state.cfg.beep_cpu_second = nxt_state.bank_sel[`BEEP_CPU2];
      nxt_state.cfg.bank = nxt_state.bank_sel[`BANK_HI:`BANK_LO];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
      state_ff.src_a <= `RST_SRC_A;
      state_ff.src_b <= `RST_SRC_B;
      state_ff.div_adc <= `RST_DIV_ADC;
      state_ff.int_ovt <= `RST_INT_OVT;
      state_ff.pin_dir <= `RST_PIN_DIR;
      state_ff.bank_sel <= `RST_BANK;
      // Inactive level for the default low-active polarity
      state_ff.overtemp_n <= 1'b1;
      state_ff.oe_n <= 3'h7;
      state_ff.cfg.aux_drive_src <= hwmon_pkg::SRC_AUX;
      state_ff.cfg.cpu_first_src <= hwmon_pkg::SRC_CPU;
      state_ff.cfg.cpu_second_src <= hwmon_pkg::SRC_SYS;
      state_ff.cfg.aux_tach_first_div <= 8'h02;
      state_ff.cfg.cpu_tach_second_div <= 8'h01;
      state_ff.cfg.adc_clk_div <= 7'h01;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata = state_ff.prdata;
  assign pready = state_ff.pready;
  assign pslverr = state_ff.pslverr;
  assign tach_drive = state_ff.drive;
  assign tach_oe_n = state_ff.oe_n;
  assign tach_sample = state_ff.sample;
  assign overtemp_out_n = state_ff.overtemp_n;
  assign fan_cfg = state_ff.cfg;

  // ==========================================================
  // Checks
  // ==========================================================
  apb_wait_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && access && !pready) |=> pready)
    else $error("pready missing after access phase");

  ident_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && access && pready && pwrite && paddr == 12'h13C)
    |=> $stable(state_ff.bank_sel) && $stable(state_ff.pin_dir))
    else $error("identifier write changed state");

  ident_byte_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && access && !pready && !pwrite && paddr == 12'h13C)
    |=> prdata[7:0] == ($past(state_ff.bank_sel[7]) ? MAKER_ID[15:8] : MAKER_ID[7:0]))
    else $error("wrong identifier byte");

  overtemp_pol_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> overtemp_out_n == ($past(state_ff.int_ovt[2]) ~^
      (($past(aux_temp_over) && !$past(state_ff.int_ovt[4])) ||
       ($past(cpu_temp_over) && !$past(state_ff.int_ovt[3])))))
    else $error("over-temperature level wrong");

  tach_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    tach_oe_n.aux == state_ff.pin_dir[4] && tach_drive.aux == state_ff.pin_dir[5])
    else $error("aux tach pin direction wrong");

  aux_source_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff.src_a[6:4] == 3'h0) |-> fan_cfg.aux_drive_src == hwmon_pkg::SRC_AUX)
    else $error("aux drive source wrong");

  second_source_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff.src_b[7:5] == 3'h7) |-> fan_cfg.cpu_second_src == hwmon_pkg::SRC_PECI4)
    else $error("second cpu drive source wrong");

  adc_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff.div_adc[5:4] == 2'h3) |-> fan_cfg.adc_clk_div == 7'h40)
    else $error("converter clock divide wrong");

  cpu_div_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff.int_ovt[7] |-> fan_cfg.cpu_tach_second_div >= 8'h10)
    else $error("second cpu divisor top bit ignored");

  bank_number_a: assert property (@(posedge pclk) disable iff (!presetn)
    fan_cfg.bank == state_ff.bank_sel[2:0])
    else $error("bank number mismatch");

endmodule : hwmon_fan_temp_config_bank
`default_nettype wire

//--- logic/hwmon_consts.svh
// Constants of the fan and temperature configuration bank: indices, fields, reset values.
// Assumes APB byte addresses equal four times the register index.
// Functional notes
// - Fan_drive_a_temp_source bits 6-4 pick the aux fan drive temperature source.
// - Fan_drive_a_temp_source bits 2-0 pick the first cpu fan drive temperature source.
// - Fan_drive_b_temp_source bits 7-5 pick the second cpu fan drive temperature source.
// - Index 4Bh bits 7-6 hold the first aux tach divisor low bits.
// - Index 4Bh bits 5-4 divide converter clock by 1, 4, 16 or 64.
// - Index 4Ch bit 7 is the second cpu tach divisor top bit.
// - 4Ch bit 6 set gives comparator interrupt mode for cpu/aux temperatures.
// - 4Ch bit 5 set gives one-time interrupt mode for sys temperature.
// - 4Ch bit 4 set keeps aux over-limit off the over-temperature output.
// - 4Ch bit 3 set keeps cpu over-limit off the over-temperature output.
// - 4Ch bit 2 sets over-temperature output polarity, one meaning active high.
// - 4Dh bit 4 set makes first aux tach pin input, else drives bit 5.
// - 4Dh bit 2 set makes first cpu tach pin input, else drives bit 3.
// - 4Dh bit 0 set makes sys tach pin input, else drives bit 1.
// - 4Eh bit 7 chooses high or low identifier byte at 4Fh.
// - 4Eh bits 5 and 4 enable beep for second aux and cpu tach.
// - 4Eh bits 2-0 give the bank number answering at 50h to 5Fh.
// - Index 4Fh reads the 16-bit identifier one byte at a time.
// - Three-bit divisor codes select division by powers of two, 1 to 128.
`ifndef HWMON_CONSTS_SVH
`define HWMON_CONSTS_SVH

`define IDX_SRC_A 10'h049
`define IDX_SRC_B 10'h04A
`define IDX_DIV_ADC 10'h04B
`define IDX_INT_OVT 10'h04C
`define IDX_PIN_DIR 10'h04D
`define IDX_BANK 10'h04E
`define IDX_MAKER 10'h04F

`define RST_SRC_A 8'h00
`define RST_SRC_B 8'h00
`define RST_DIV_ADC 8'h44
`define RST_INT_OVT 8'h10
`define RST_PIN_DIR 8'h95
`define RST_BANK 8'h80

`define SRC_A_AUX_HI 6
`define SRC_A_AUX_LO 4
`define SRC_A_CPU_HI 2
`define SRC_A_CPU_LO 0
`define SRC_B_HI 7
`define SRC_B_LO 5
`define DIV_AUX_HI 7
`define DIV_AUX_LO 6
`define ADC_HI 5
`define ADC_LO 4
`define INT_CPU2_DIV_MSB 7
`define INT_CMP_MODE 6
`define INT_SYS_ONCE 5
`define OVT_AUX_DIS 4
`define OVT_CPU_DIS 3
`define OVT_POL 2
`define PIN_AUX_VAL 5
`define PIN_AUX_IN 4
`define PIN_CPU_VAL 3
`define PIN_CPU_IN 2
`define PIN_SYS_VAL 1
`define PIN_SYS_IN 0
`define BANK_HI_BYTE 7
`define BEEP_AUX2 5
`define BEEP_CPU2 4
`define BANK_HI 2
`define BANK_LO 0

`endif

//--- logic/hwmon_pkg.sv
// Types of the fan and temperature configuration bank.
// Assumes hwmon_consts.svh is compiled alongside for the numeric constants.
`default_nettype none
package hwmon_pkg;

  typedef enum logic [2:0] {
    SRC_SYS, SRC_CPU, SRC_AUX, SRC_PECI1, SRC_PECI2, SRC_PECI3, SRC_PECI4, SRC_NONE
  } temp_src_t;

  typedef struct packed {
    logic aux;
    logic cpu;
    logic sys;
  } tach_t;

  typedef struct packed {
    temp_src_t aux_drive_src;
    temp_src_t cpu_first_src;
    temp_src_t cpu_second_src;
    logic [7:0] aux_tach_first_div;
    logic [7:0] cpu_tach_second_div;
    logic [6:0] adc_clk_div;
    logic cmp_int_mode;
    logic sys_once_int_mode;
    logic beep_aux_second;
    logic beep_cpu_second;
    logic [2:0] bank;
  } fan_cfg_t;

  typedef struct packed {
    logic [7:0] src_a;
    logic [7:0] src_b;
    logic [7:0] div_adc;
    logic [7:0] int_ovt;
    logic [7:0] pin_dir;
    logic [7:0] bank_sel;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic overtemp_n;
    tach_t drive;
    tach_t oe_n;
    tach_t sample;
    fan_cfg_t cfg;
  } state_t;

endpackage : hwmon_pkg
`default_nettype wire

//--- bench/test_hwmon_fan_temp_config_bank.sv
// ==========================================================
// Self-checking bench for the fan and temperature configuration bank.
// Assumes the logic/ files are compiled first; the bench is the APB master and pin driver.
`timescale 1ns/1ps
`include "hwmon_consts.svh"
`default_nettype none
`define chk(got, exp) begin checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end
module test_hwmon_fan_temp_config_bank;
  // Identifier value is arbitrary
  localparam logic [15:0] ID = 16'hB7C4;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic aux_temp_over, cpu_temp_over, aux_tach_first_div_msb, overtemp_out_n, err, act;
  logic [1:0] cpu_tach_second_div_low;
  logic [2:0] k;
  logic [7:0] rd;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] rst_tab [6] = '{`RST_SRC_A, `RST_SRC_B, `RST_DIV_ADC, `RST_INT_OVT,
    `RST_PIN_DIR, `RST_BANK};
  // Expected divide ratios written out per code, not computed like the logic does
  logic [6:0] adc_tab [4] = '{7'h01, 7'h04, 7'h10, 7'h40};
  logic [7:0] div_tab [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
  hwmon_pkg::tach_t tach_in, tach_drive, tach_oe_n, tach_sample;
  hwmon_pkg::fan_cfg_t fan_cfg;
  int mismatches = 0;
  int checked = 0;

  hwmon_fan_temp_config_bank #(.MAKER_ID(ID)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .aux_temp_over(aux_temp_over), .cpu_temp_over(cpu_temp_over),
    .aux_tach_first_div_msb(aux_tach_first_div_msb),
    .cpu_tach_second_div_low(cpu_tach_second_div_low), .tach_in(tach_in),
    .tach_drive(tach_drive), .tach_oe_n(tach_oe_n), .tach_sample(tach_sample),
    .overtemp_out_n(overtemp_out_n), .fan_cfg(fan_cfg));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ==========================================================
  // Closing and watchdog
  task automatic tally_and_finish();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  // About 900 cycles of traffic are expected; the limit of 10000 cycles leaves a wide margin
  initial begin
    #400000;
    mismatches++;
    tally_and_finish();
  end

  // ==========================================================
  // APB master
  // Answer is read just after the rising edge, before the slave's flops move on
  task automatic xfer(input logic [9:0] idx, input logic [1:0] lo, input logic w,
      input logic [7:0] d, input logic [3:0] s, output logic [7:0] rdv, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, lo};
    pwdata <= {24'h000000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never completes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata[7:0];
    e = pslverr;
    `chk(prdata[31:8], 24'h000000)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    xfer(idx, 2'b00, 1'b1, d, 4'hF, rd, err);
    `chk(err, 1'b0)
  endtask : wr

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] exp);
    xfer(idx, 2'b00, 1'b0, 8'h00, 4'h0, rd, err);
    `chk(rd, exp)
    `chk(err, 1'b0)
  endtask : rdchk

  task automatic settle();
    @(negedge pclk);
  endtask : settle

  function automatic hwmon_pkg::temp_src_t src_first(input logic [2:0] c,
      input hwmon_pkg::temp_src_t base);
    if (c == 3'd0) return base;
    if (c == 3'd1) return hwmon_pkg::SRC_NONE;
    return hwmon_pkg::temp_src_t'(c + 3'd1);
  endfunction : src_first

  function automatic hwmon_pkg::temp_src_t src_second(input logic [2:0] c);
    if (c < 3'd3) return hwmon_pkg::temp_src_t'(c);
    if (c == 3'd3) return hwmon_pkg::SRC_NONE;
    return hwmon_pkg::temp_src_t'(c - 3'd1);
  endfunction : src_second

  // ==========================================================
  // Tests
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    aux_temp_over = 1'b0;
    cpu_temp_over = 1'b0;
    aux_tach_first_div_msb = 1'b0;
    cpu_tach_second_div_low = 2'b00;
    tach_in = 3'b000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    `chk(fan_cfg.aux_drive_src, hwmon_pkg::SRC_AUX)
    `chk(fan_cfg.cpu_first_src, hwmon_pkg::SRC_CPU)
    `chk(fan_cfg.cpu_second_src, hwmon_pkg::SRC_SYS)
    `chk(fan_cfg.aux_tach_first_div, 8'h02)
    `chk(fan_cfg.adc_clk_div, 7'h01)
    `chk(tach_oe_n, 3'b111)
    for (int i = 0; i < 6; i++) rdchk(`IDX_SRC_A + 10'(i), rst_tab[i]);
    rdchk(`IDX_MAKER, ID[15:8]);
    wr(`IDX_BANK, 8'h00);
    rdchk(`IDX_MAKER, ID[7:0]);
    xfer(`IDX_MAKER, 2'b00, 1'b1, 8'hFF, 4'hF, rd, err);
    `chk(err, 1'b0)
    rdchk(`IDX_BANK, 8'h00);
    rdchk(`IDX_MAKER, ID[7:0]);
    for (int c = 0; c < 8; c++) begin
      k = 3'(c % 6);
      wr(`IDX_SRC_A, {1'b0, k, 1'b0, k});
      wr(`IDX_SRC_B, {c[2:0], 5'h00});
      settle();
      `chk(fan_cfg.aux_drive_src, src_first(k, hwmon_pkg::SRC_AUX))
      `chk(fan_cfg.cpu_first_src, src_first(k, hwmon_pkg::SRC_CPU))
      `chk(fan_cfg.cpu_second_src, src_second(c[2:0]))
      rdchk(`IDX_SRC_B, {c[2:0], 5'h00});
    end
    for (int c = 0; c < 8; c++) begin
      k = c[2:0];
      @(posedge pclk);
      aux_tach_first_div_msb <= k[2];
      cpu_tach_second_div_low <= k[1:0];
      wr(`IDX_DIV_ADC, {k[1:0], k[1:0], 4'h4});
      wr(`IDX_INT_OVT, {k[2], k[0], k[1], 5'h10});
      settle();
      `chk(fan_cfg.aux_tach_first_div, div_tab[k])
      `chk(fan_cfg.cpu_tach_second_div, div_tab[k])
      `chk(fan_cfg.adc_clk_div, adc_tab[k[1:0]])
      `chk(fan_cfg.cmp_int_mode, k[0])
      `chk(fan_cfg.sys_once_int_mode, k[1])
    end
    for (int i = 0; i < 32; i++) begin
      wr(`IDX_INT_OVT, {3'b000, i[4:2], 2'b00});
      @(posedge pclk);
      aux_temp_over <= i[1];
      cpu_temp_over <= i[0];
      settle();
      settle();
      act = (i[1] & ~i[4]) | (i[0] & ~i[3]);
      `chk(overtemp_out_n, i[2] ? act : ~act)
    end
    for (int i = 0; i < 64; i++) begin
      @(posedge pclk);
      tach_in <= i[2:0];
      wr(`IDX_PIN_DIR, {2'b00, i[5:0]});
      settle();
      `chk(tach_oe_n, {i[4], i[2], i[0]})
      `chk(tach_drive & ~tach_oe_n, {i[5], i[3], i[1]} & ~{i[4], i[2], i[0]})
      `chk(tach_sample, i[2:0])
    end
    // Clock enable low freezes every flop, the pin sample included
    @(posedge pclk);
    ce <= 1'b0;
    tach_in <= 3'b010;
    repeat (3) settle();
    `chk(tach_sample, 3'b111)
    @(posedge pclk);
    ce <= 1'b1;
    settle();
    settle();
    `chk(tach_sample, 3'b010)
    for (int i = 0; i < 8; i++) begin
      wr(`IDX_BANK, {2'b10, i[1:0], 1'b0, i[2:0]});
      settle();
      `chk(fan_cfg.bank, i[2:0])
      `chk({fan_cfg.beep_aux_second, fan_cfg.beep_cpu_second}, i[1:0])
      rdchk(`IDX_BANK, {2'b10, i[1:0], 1'b0, i[2:0]});
    end
    // Unmapped, misaligned and strobe-less accesses leave the register alone
    wr(`IDX_SRC_A, 8'h25);
    xfer(10'h054, 2'b00, 1'b0, 8'h00, 4'h0, rd, err);
    `chk({err, rd}, 9'h100)
    xfer(`IDX_SRC_A, 2'b01, 1'b1, 8'h66, 4'hF, rd, err);
    `chk(err, 1'b1)
    xfer(`IDX_SRC_A, 2'b00, 1'b1, 8'h77, 4'h0, rd, err);
    `chk(err, 1'b0)
    rdchk(`IDX_SRC_A, 8'h25);
    tally_and_finish();
  end
endmodule : test_hwmon_fan_temp_config_bank
`default_nettype wire
